// File: core/alts_defs.svh
// Purpose: Constants for the AUX snoop shadow register bank
// Assumes: 10 MHz core clock, 1 Mbps Manchester AUX
// Notes:   Offsets are AUX configuration addresses, not a CPU bus
//
// Overview of operation
// [R1] Written bits 1:0 of the lane 1 drive register select swing level 0..3.
// [R2] Written bits 4:3 of the lane 1 drive register select pre-emphasis 0..3.
// [R3] Swing/pre-emphasis pairs 01/11, 10/10, 10/11 disable all output lanes.
// [R4] Drive read-back packs swing in bits 1:0 and pre-emphasis in bits 3:2.
// [R5] Lane 1 drive register has its own address and controls output lane 1.
// [R6] Post-cursor bits 1:0 give lane 0 input level; output lane 0 sends level 0.
// [R7] Post-cursor bits 5:4 give lane 1 input level; output lane 1 sends level 0.
// [R8] Post-cursor read-back packs lane 0 in bits 1:0, lane 1 in bits 3:2.
// [R9] A second post-cursor register with same layout serves lanes 2 and 3.
// [R10] Power field bits 1:0: 01 selects normal, 10 selects standby.
// [R11] Standby shuts main link and analog parts but keeps AUX snooping.
// [R12] Standby ends on power register access, adapter detect rise, or hot-plug timeout.
// [R13] Writes of 00 or 11 to the power field are ignored; normal mode kept.
// [R14] Power read-back gives 00 for normal and 01 for standby.
// [R15] Snooping runs only in packetised mode, never in TMDS modes.
// [R16] Reserved bits written over AUX are ignored.
// [R17] Shadows update only on a completed native write, bytes at successive addresses.
// [R18] Source writes only valid drive and power combinations; the bench also writes the invalid pairs and power values 00 and 11.
`ifndef ALTS_DEFS_SVH
`define ALTS_DEFS_SVH

`define ALTS_ADDR_LANE1_DRIVE    20'h00104
`define ALTS_ADDR_POST01         20'h0010F
`define ALTS_ADDR_POWER          20'h00600
`define ALTS_ADDR_POST23         20'h0110F

`define ALTS_CMD_NATIVE_WR       4'h8
`define ALTS_CMD_NATIVE_RD       4'h9
`define ALTS_HDR_BITS            6'h20

`define ALTS_WR_SWING_LSB        0
`define ALTS_WR_PRE_LSB          3
`define ALTS_WR_POSTA_LSB        0
`define ALTS_WR_POSTB_LSB        4

`define ALTS_PWR_NORMAL_WR       2'h1
`define ALTS_PWR_STANDBY_WR      2'h2
`define ALTS_PWR_NORMAL_RD       2'h0
`define ALTS_PWR_STANDBY_RD      2'h1
`define ALTS_POST_TX_LEVEL       2'h0

`define ALTS_CLK_PERIOD_NS       100
`define ALTS_AUX_BIT_NS          1000
`define ALTS_SYNC_MIN_NS         1500
`define ALTS_SYNC_MAX_NS         2500
`define ALTS_FIRST_MID_NS        2250
`define ALTS_FIRST_END_NS        3000
`define ALTS_HPD_TIMEOUT_US      2000

`define ALTS_SYNC_MIN_CYC  6'((`ALTS_SYNC_MIN_NS + `ALTS_CLK_PERIOD_NS - 1) / `ALTS_CLK_PERIOD_NS)
`define ALTS_SYNC_MAX_CYC  6'(`ALTS_SYNC_MAX_NS / `ALTS_CLK_PERIOD_NS)
`define ALTS_MID_MIN_CYC   6'((`ALTS_AUX_BIT_NS * 3 / 4) / `ALTS_CLK_PERIOD_NS)
`define ALTS_FIRST_MID_CYC 6'(`ALTS_FIRST_MID_NS / `ALTS_CLK_PERIOD_NS)
`define ALTS_END_CYC       6'((`ALTS_SYNC_MIN_NS + `ALTS_CLK_PERIOD_NS - 1) / `ALTS_CLK_PERIOD_NS)
`define ALTS_FIRST_END_CYC 6'(`ALTS_FIRST_END_NS / `ALTS_CLK_PERIOD_NS)
`define ALTS_HPD_TIMEOUT_CYC 16'(`ALTS_HPD_TIMEOUT_US * 1000 / `ALTS_CLK_PERIOD_NS)

`endif

// File: core/alts_pkg.sv
// Purpose: Types for the AUX snoop shadow register bank
// Assumes: Constants come from alts_defs.svh
// Notes:   The whole module state is one packed struct
package alts_pkg;

    typedef enum logic {
        ALTS_IDLE,
        ALTS_FRAME
    } alts_phase_t;

    typedef struct packed {
        logic [2:0]  aux_s;
        logic [2:0]  cad_s;
        logic [2:0]  hpd_s;
        logic        aux_f;
        logic        cad_f;
        logic        hpd_f;
        alts_phase_t phase;
        logic [5:0]  run_cnt;
        logic [5:0]  tmr;
        logic        first;
        logic [5:0]  hcnt;
        logic [31:0] hdr;
        logic [7:0]  sh;
        logic [2:0]  bcnt;
        logic [4:0]  nbytes;
        logic [19:0] cur_addr;
        logic [3:0]  stg_l1;
        logic [3:0]  stg_p01;
        logic [3:0]  stg_p23;
        logic [1:0]  stg_pw;
        logic        hit_l1;
        logic        hit_p01;
        logic        hit_p23;
        logic        hit_pw;
        logic [1:0]  swing;
        logic [1:0]  pre;
        logic        bad;
        logic [3:0]  p01;
        logic [3:0]  p23;
        logic        standby;
        logic [15:0] hpd_cnt;
    } alts_state_t;

endpackage : alts_pkg

// File: core/alts_snoop_regs.sv
// Purpose: Shadow link configuration kept by snooping source writes on AUX
// Assumes: aux_rx is the received AUX level; one 10 MHz clock
// Notes:   Manchester decoding is edge based; mid-bit rising edge is a one
`include "alts_defs.svh"

module alts_snoop_regs #(
    parameter logic [15:0] HPD_TIMEOUT_CYC = `ALTS_HPD_TIMEOUT_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       dp_mode,
    input  wire logic       aux_rx,
    input  wire logic       cable_adapter_detect,
    input  wire logic       sink_hot_plug_in,
    output logic [1:0]      output_swing_level,
    output logic [1:0]      pre_emphasis_level,
    output logic            main_link_enable,
    output logic            analog_enable,
    output logic            low_power_standby,
    output logic [7:0]      post_cursor_expect,
    output logic [7:0]      post_cursor_transmit,
    output logic [7:0]      lane1_drive_set_rd,
    output logic [7:0]      lane01_post_cursor_set_rd,
    output logic [7:0]      lane23_post_cursor_set_rd,
    output logic [7:0]      sink_power_state_rd
);
    import alts_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic bad_pair(input logic [1:0] sw, input logic [1:0] pe);
        bad_pair = ({sw, pe} == 4'h7) || ({sw, pe} == 4'hA) || ({sw, pe} == 4'hB); // [R3]
    endfunction : bad_pair

    function automatic logic [3:0] post_fields(input logic [7:0] b);
        post_fields = {b[`ALTS_WR_POSTB_LSB +: 2], b[`ALTS_WR_POSTA_LSB +: 2]}; // [R6] [R7] [R16]
    endfunction : post_fields

    function automatic logic [5:0] sat_inc(input logic [5:0] v);
        sat_inc = (v == 6'h3F) ? v : v + 6'h01;
    endfunction : sat_inc

    alts_state_t q_ff;
    alts_state_t nxt_q;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic        edge_seen;
        logic        new_lvl;
        logic        bit_ok;
        logic        bit_val;
        logic [7:0]  byte_val;
        logic        frame_end;
        logic        complete;
        logic        is_wr;
        logic        rd_touch;
        logic [19:0] span;
        edge_seen = 1'b0;
        new_lvl   = 1'b0;
        bit_ok    = 1'b0;
        bit_val   = 1'b0;
        byte_val  = 8'h00;
        frame_end = 1'b0;
        complete  = 1'b0;
        is_wr     = 1'b0;
        rd_touch  = 1'b0;
        span      = 20'h00000;
        nxt_q     = q_ff;

        // Three-stage synchronisers; a change counts once stages two and three agree
        nxt_q.aux_s = {q_ff.aux_s[1:0], aux_rx};
        nxt_q.cad_s = {q_ff.cad_s[1:0], cable_adapter_detect};
        nxt_q.hpd_s = {q_ff.hpd_s[1:0], sink_hot_plug_in};
        if (q_ff.aux_s[1] == q_ff.aux_s[2]) begin
            nxt_q.aux_f = q_ff.aux_s[2];
        end
        if (q_ff.cad_s[1] == q_ff.cad_s[2]) begin
            nxt_q.cad_f = q_ff.cad_s[2];
        end
        if (q_ff.hpd_s[1] == q_ff.hpd_s[2]) begin
            nxt_q.hpd_f = q_ff.hpd_s[2];
        end
        edge_seen = (nxt_q.aux_f != q_ff.aux_f);
        new_lvl   = nxt_q.aux_f;

        case (q_ff.phase)
            ALTS_IDLE: begin
                nxt_q.run_cnt = q_ff.aux_f ? sat_inc(q_ff.run_cnt) : 6'h00;
                // Only the long sync-end high can start a frame; preamble halves are short
                if (edge_seen && !new_lvl && q_ff.run_cnt >= `ALTS_SYNC_MIN_CYC &&
                    q_ff.run_cnt <= `ALTS_SYNC_MAX_CYC) begin
                    nxt_q.phase   = ALTS_FRAME;
                    nxt_q.tmr     = 6'h00;
                    nxt_q.first   = 1'b1;
                    nxt_q.hcnt    = 6'h00;
                    nxt_q.bcnt    = 3'h0;
                    nxt_q.nbytes  = 5'h00;
                    nxt_q.hit_l1  = 1'b0;
                    nxt_q.hit_p01 = 1'b0;
                    nxt_q.hit_p23 = 1'b0;
                    nxt_q.hit_pw  = 1'b0;
                end
            end
            ALTS_FRAME: begin
                nxt_q.tmr = sat_inc(q_ff.tmr);
                // Boundary edges fall before the threshold and are skipped
                if (edge_seen) begin
                    bit_ok = q_ff.first ? (q_ff.tmr >= `ALTS_FIRST_MID_CYC)
                                        : (q_ff.tmr >= `ALTS_MID_MIN_CYC);
                end
                frame_end = q_ff.first ? (q_ff.tmr >= `ALTS_FIRST_END_CYC)
                                       : (q_ff.tmr >= `ALTS_END_CYC);
                if (bit_ok) begin
                    bit_val     = new_lvl;
                    nxt_q.tmr   = 6'h00;
                    nxt_q.first = 1'b0;
                    if (q_ff.hcnt < `ALTS_HDR_BITS) begin
                        nxt_q.hdr  = {q_ff.hdr[30:0], bit_val};
                        nxt_q.hcnt = q_ff.hcnt + 6'h01;
                        nxt_q.cur_addr = nxt_q.hdr[27:8];
                    end else begin
                        nxt_q.sh   = {q_ff.sh[6:0], bit_val};
                        nxt_q.bcnt = q_ff.bcnt + 3'h1;
                        if (q_ff.bcnt == 3'h7) begin
                            byte_val = nxt_q.sh;
                            if (q_ff.hdr[31:28] == `ALTS_CMD_NATIVE_WR) begin // [R17]
                                case (q_ff.cur_addr)
                                    `ALTS_ADDR_LANE1_DRIVE: begin // [R5]
                                        nxt_q.stg_l1 = {byte_val[`ALTS_WR_PRE_LSB +: 2],
                                                        byte_val[`ALTS_WR_SWING_LSB +: 2]}; // [R1] [R2] [R16]
                                        nxt_q.hit_l1 = 1'b1;
                                    end
                                    `ALTS_ADDR_POST01: begin
                                        nxt_q.stg_p01 = post_fields(byte_val);
                                        nxt_q.hit_p01 = 1'b1;
                                    end
                                    `ALTS_ADDR_POST23: begin
                                        nxt_q.stg_p23 = post_fields(byte_val); // [R9]
                                        nxt_q.hit_p23 = 1'b1;
                                    end
                                    `ALTS_ADDR_POWER: begin
                                        nxt_q.stg_pw = byte_val[1:0]; // [R10] [R16]
                                        nxt_q.hit_pw = 1'b1;
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                            nxt_q.cur_addr = q_ff.cur_addr + 20'h00001; // [R17]
                            nxt_q.nbytes   = (q_ff.nbytes == 5'h1F) ? q_ff.nbytes
                                                                    : q_ff.nbytes + 5'h01;
                        end
                    end
                end else if (frame_end) begin
                    nxt_q.phase   = ALTS_IDLE;
                    nxt_q.run_cnt = 6'h00;
                    complete = (q_ff.hcnt == `ALTS_HDR_BITS) && (q_ff.bcnt == 3'h0);
                    is_wr    = complete && (q_ff.hdr[31:28] == `ALTS_CMD_NATIVE_WR) &&
                               ({3'h0, q_ff.nbytes} == q_ff.hdr[7:0] + 8'h01);
                    span     = `ALTS_ADDR_POWER - q_ff.hdr[27:8];
                    rd_touch = complete && (q_ff.hdr[31:28] == `ALTS_CMD_NATIVE_RD) &&
                               (q_ff.hdr[27:8] <= `ALTS_ADDR_POWER) &&
                               (span <= {12'h000, q_ff.hdr[7:0]});
                end
            end
            default: begin
                nxt_q.phase = ALTS_IDLE;
            end
        endcase

        // Commit staged shadows only at the end of a whole native write
        if (is_wr && q_ff.hit_l1) begin // [R17]
            nxt_q.swing = q_ff.stg_l1[1:0]; // [R1]
            nxt_q.pre   = q_ff.stg_l1[3:2]; // [R2]
            nxt_q.bad   = bad_pair(q_ff.stg_l1[1:0], q_ff.stg_l1[3:2]); // [R3]
        end
        if (is_wr && q_ff.hit_p01) begin
            nxt_q.p01 = q_ff.stg_p01; // [R6] [R7]
        end
        if (is_wr && q_ff.hit_p23) begin
            nxt_q.p23 = q_ff.stg_p23; // [R9]
        end
        // Any access leaves standby; only a 10 write enters it, 00 and 11 keep normal
        if (is_wr && q_ff.hit_pw) begin
            nxt_q.standby = (q_ff.stg_pw == `ALTS_PWR_STANDBY_WR); // [R10] [R12] [R13]
        end
        if (rd_touch) begin
            nxt_q.standby = 1'b0; // [R12]
        end

        // Hot-plug low timer saturates at the timeout
        if (q_ff.hpd_f) begin
            nxt_q.hpd_cnt = 16'h0000;
        end else if (q_ff.hpd_cnt < HPD_TIMEOUT_CYC) begin
            nxt_q.hpd_cnt = q_ff.hpd_cnt + 16'h0001;
        end
        // External wake events win over a standby write in the same cycle
        if ((nxt_q.cad_f && !q_ff.cad_f) || (q_ff.hpd_cnt >= HPD_TIMEOUT_CYC)) begin
            nxt_q.standby = 1'b0; // [R12]
        end

        // TMDS modes: the snooper is held idle and any frame in flight is dropped
        if (!dp_mode) begin
            nxt_q.phase   = ALTS_IDLE; // [R15]
            nxt_q.run_cnt = 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign output_swing_level        = q_ff.swing;
    assign pre_emphasis_level        = q_ff.pre;
    assign main_link_enable          = !q_ff.bad && !q_ff.standby; // [R3] [R11]
    assign analog_enable             = !q_ff.standby; // [R11]
    assign low_power_standby         = q_ff.standby;
    assign post_cursor_expect        = {q_ff.p23, q_ff.p01};
    assign post_cursor_transmit      = {4{`ALTS_POST_TX_LEVEL}}; // [R6] [R7]
    assign lane1_drive_set_rd        = {4'h0, q_ff.pre, q_ff.swing}; // [R4]
    assign lane01_post_cursor_set_rd = {4'h0, q_ff.p01}; // [R8]
    assign lane23_post_cursor_set_rd = {4'h0, q_ff.p23}; // [R8] [R9]
    assign sink_power_state_rd       = {6'h00, q_ff.standby ? `ALTS_PWR_STANDBY_RD
                                                            : `ALTS_PWR_NORMAL_RD}; // [R14]

endmodule : alts_snoop_regs

// File: sim/alts_aux_src.sv
// Purpose: AUX source model that sends Manchester frames to the snooper
// Assumes: 2 bit-clock halves of 5 cycles each at 10 MHz
// Notes:   Line rests low between frames so no stray sync appears
module alts_aux_src (
    input  wire logic clk,
    output logic      aux_rx
);
    timeunit 1ns;
    timeprecision 1ns;

    initial aux_rx = 1'b0;

    task automatic hold(input logic v, input int n);
        aux_rx <= v;
        repeat (n) @(posedge clk);
    endtask : hold

    // Sends exactly what the bench commands; invalid pairs only on request
    task automatic send(input logic [3:0] cmd, input logic [19:0] addr, input logic [7:0] len,
                        input logic [15:0] data, input int nb);
        logic [47:0] f;
        f = {cmd, addr, len, data};
        hold(1'b1, 20);
        hold(1'b0, 20);
        for (int i = 0; i < 32 + 8 * nb; i++) begin
            hold(~f[47-i], 5);
            hold(f[47-i], 5);
        end
        // Stop pattern, long enough for the frame-end timeout to elapse, then a quiet gap
        hold(1'b1, 20);
        hold(1'b0, 60);
    endtask : send
endmodule : alts_aux_src

// File: sim/alts_snoop_regs_sva.sv
// Purpose: Port-level checks for the AUX snoop shadow bank
// Assumes: One clock, async active-high reset
// Notes:   Wake bounds allow for the 3-flop input synchronisers
module alts_snoop_regs_chk #(
    parameter logic [15:0] HPD_TIMEOUT_CYC = 16'h4E20
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       dp_mode,
    input wire logic       cable_adapter_detect,
    input wire logic       sink_hot_plug_in,
    input wire logic [1:0] output_swing_level,
    input wire logic [1:0] pre_emphasis_level,
    input wire logic       main_link_enable,
    input wire logic       analog_enable,
    input wire logic       low_power_standby,
    input wire logic [7:0] post_cursor_expect,
    input wire logic [7:0] post_cursor_transmit,
    input wire logic [7:0] lane1_drive_set_rd,
    input wire logic [7:0] lane01_post_cursor_set_rd,
    input wire logic [7:0] lane23_post_cursor_set_rd,
    input wire logic [7:0] sink_power_state_rd
);
    logic [16:0] hpd_lo_ff;
    logic [16:0] nxt_hpd_lo;
    logic        bad_pair;

    // Saturating count so a long unplug never wraps back to zero
    assign nxt_hpd_lo = sink_hot_plug_in ? 17'h00000 : (hpd_lo_ff[16] ? hpd_lo_ff : hpd_lo_ff + 17'h1);
    assign bad_pair = (output_swing_level == 2'h1 && pre_emphasis_level == 2'h3) ||
                      (output_swing_level == 2'h2 && pre_emphasis_level[1]);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hpd_lo_ff <= 17'h00000;
        end else begin
            hpd_lo_ff <= nxt_hpd_lo;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_tmds_quiet;
        !dp_mode [*8];
    endsequence
    sequence s_adapter_rise;
        low_power_standby && $rose(cable_adapter_detect);
    endsequence

    a_tx_level_zero: assert property (post_cursor_transmit == 8'h00)
        else $error("post cursor transmit level not zero");
    a_drive_read_pack: assert property (lane1_drive_set_rd == {4'h0, pre_emphasis_level, output_swing_level})
        else $error("drive read-back packing wrong");
    a_post01_read: assert property (lane01_post_cursor_set_rd == {4'h0, post_cursor_expect[3:0]})
        else $error("lane 0/1 post cursor read-back wrong");
    a_post23_read: assert property (lane23_post_cursor_set_rd == {4'h0, post_cursor_expect[7:4]})
        else $error("lane 2/3 post cursor read-back wrong");
    a_power_read: assert property (sink_power_state_rd == {7'h00, low_power_standby})
        else $error("power read-back wrong");
    a_analog_off: assert property (analog_enable == !low_power_standby)
        else $error("analog enable disagrees with standby");
    a_lane_disable: assert property (main_link_enable == !(low_power_standby || bad_pair))
        else $error("main link enable wrong for drive pair");
    a_tmds_frozen: assert property (s_tmds_quiet |-> $stable(lane1_drive_set_rd) && $stable(post_cursor_expect))
        else $error("shadow changed with snooping off");
    a_adapter_wake: assert property (s_adapter_rise |-> ##[1:8] !low_power_standby)
        else $error("adapter detect did not end standby");
    a_hpd_wake: assert property (hpd_lo_ff > {1'b0, HPD_TIMEOUT_CYC} + 17'h8 |-> !low_power_standby)
        else $error("hot-plug timeout did not end standby");
endmodule : alts_snoop_regs_chk

bind alts_snoop_regs alts_snoop_regs_chk #(.HPD_TIMEOUT_CYC(HPD_TIMEOUT_CYC)) i_alts_chk (
    .clk(clk), .reset(reset), .dp_mode(dp_mode), .cable_adapter_detect(cable_adapter_detect),
    .sink_hot_plug_in(sink_hot_plug_in), .output_swing_level(output_swing_level),
    .pre_emphasis_level(pre_emphasis_level), .main_link_enable(main_link_enable),
    .analog_enable(analog_enable), .low_power_standby(low_power_standby),
    .post_cursor_expect(post_cursor_expect), .post_cursor_transmit(post_cursor_transmit),
    .lane1_drive_set_rd(lane1_drive_set_rd), .lane01_post_cursor_set_rd(lane01_post_cursor_set_rd),
    .lane23_post_cursor_set_rd(lane23_post_cursor_set_rd), .sink_power_state_rd(sink_power_state_rd)
);

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the AUX snoop shadow bank
// Assumes: Hot-plug timeout shortened to 50 cycles
// Notes:   Model state is kept in plain integers
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import alts_pkg::*;

    logic clk, reset, dp_mode, aux_rx, cad, hpd, mle, ana, sbo;
    logic [1:0] swo, peo;
    logic [7:0] pce, pct, rd_l1, rd_p01, rd_p23, rd_pw;
    int error_cnt, samples_checked, cyc, sw, pe, p01, p23, sb;
    logic [31:0] r;

    alts_aux_src i_alts_aux_src (.clk(clk), .aux_rx(aux_rx));
    alts_snoop_regs #(.HPD_TIMEOUT_CYC(16'h0032)) i_alts_snoop_regs (
        .clk(clk), .reset(reset), .dp_mode(dp_mode), .aux_rx(aux_rx),
        .cable_adapter_detect(cad), .sink_hot_plug_in(hpd), .output_swing_level(swo),
        .pre_emphasis_level(peo), .main_link_enable(mle), .analog_enable(ana),
        .low_power_standby(sbo), .post_cursor_expect(pce), .post_cursor_transmit(pct),
        .lane1_drive_set_rd(rd_l1), .lane01_post_cursor_set_rd(rd_p01),
        .lane23_post_cursor_set_rd(rd_p23), .sink_power_state_rd(rd_pw));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    // Ceiling is about two and a half times the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not complete", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmp_all();
        logic bad;
        bad = (sw == 1 && pe == 3) || (sw == 2 && pe >= 2);
        chk({6'h00, swo}, 8'(sw));
        chk({6'h00, peo}, 8'(pe));
        chk({7'h00, mle}, {7'h00, !bad && sb == 0});
        chk(rd_l1, 8'(pe * 4 + sw));
        chk(pce, 8'(p23 * 16 + p01));
        chk(pct, 8'h00);
        chk(rd_p01, 8'(p01));
        chk(rd_p23, 8'(p23));
        chk({7'h00, ana}, {7'h00, sb == 0});
        chk({7'h00, sbo}, 8'(sb));
        chk(rd_pw, 8'(sb));
    endtask : cmp_all

    // Reserved bits are dropped by masking, so random upper bits must not matter
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        i_alts_aux_src.send(4'h8, a, 8'h00, {d, 8'h00}, 1);
        case (a)
            20'h00104: begin sw = d[1:0]; pe = d[4:3]; end
            20'h0010F: p01 = {d[5:4], d[1:0]};
            20'h0110F: p23 = {d[5:4], d[1:0]};
            20'h00600: sb = (d[1:0] == 2'h2);
            default: ;
        endcase
    endtask : wr

    initial begin
        reset = 1'b1; dp_mode = 1'b1; cad = 1'b0; hpd = 1'b1;
        sw = 0; pe = 0; p01 = 0; p23 = 0; sb = 0; r = $urandom(5);
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_all();
        $display("test reset_values done");
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            wr(20'h00104, {r[7:5], 2'(i >> 2), r[2], 2'(i)});
            cmp_all();
        end
        wr(20'h00104, 8'h09);
        $display("test drive_pairs done");
        for (int i = 0; i < 4; i++) begin
            wr(20'h0010F, 8'($urandom));
            wr(20'h0110F, 8'($urandom));
            cmp_all();
        end
        $display("test post_cursor done");
        i_alts_aux_src.send(4'h8, 20'h0010E, 8'h01, 16'hA533, 2);
        p01 = 4'hF;
        cmp_all();
        i_alts_aux_src.send(4'h4, 20'h00104, 8'h00, 16'h1F00, 1);
        cmp_all();
        dp_mode <= 1'b0;
        i_alts_aux_src.send(4'h8, 20'h00104, 8'h00, 16'h0B00, 1);
        dp_mode <= 1'b1;
        cmp_all();
        $display("test frame_filter done");
        foreach (r[i]) if (i < 5) begin
            wr(20'h00600, 8'(32'h01032002 >> (i * 8)));
            cmp_all();
        end
        wr(20'h00600, 8'h02);
        i_alts_aux_src.send(4'h9, 20'h00600, 8'h00, 16'h0000, 0);
        sb = 0;
        cmp_all();
        wr(20'h00600, 8'h02);
        cad <= 1'b1;
        repeat (20) @(posedge clk);
        cad <= 1'b0;
        sb = 0;
        cmp_all();
        wr(20'h00600, 8'h02);
        cmp_all();
        hpd <= 1'b0;
        repeat (80) @(posedge clk);
        hpd <= 1'b1;
        sb = 0;
        cmp_all();
        $display("test power_states done");
        finish_test();
    end
endmodule : tb_top
